// File: rem_edge_detect.sv
`timescale 1ns/1ns

module rem_edge_detect
  import rem_pkg::*;
#(
  parameter int W = 2
)
(
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] level;
  logic [W-1:0] prev;
  logic         primed;
  logic         seen;
  logic [W-1:0] next_level;
  logic [W-1:0] next_prev;
  logic         next_primed;
  logic         next_seen;

  always_comb
  begin
    next_level  = level_i;
    next_prev   = level;
    next_seen   = 1'b1;
    next_primed = seen;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      level  <= '0;
      prev   <= '0;
      primed <= 1'b0;
      seen   <= 1'b0;
    end
    else
    begin
      level  <= next_level;
      prev   <= next_prev;
      primed <= next_primed;
      seen   <= next_seen;
    end
  end

  // No edges until prev holds a real sample, so reset is not an event
  assign level_o = level;
  assign rise_o  = level & ~prev & {W{primed}};
  assign fall_o  = ~level & prev & {W{primed}};

endmodule

// File: rem_event_mask_bank.sv
`timescale 1ns/1ns
`include "rem_regs.svh"

// Functional notes
// R1 - The register-reset event is passed on only while top mask 2 bit 0 is 0.
// R2 - Serial writes to top mask 2 bit 0 are ignored; it reloads from OTP.
// R3 - Converter mask at 0x22, bit 7 blocks the converter-1 pg-invalid event.
// R4 - Converter mask bit 6 blocks the converter-1 pg-valid event.
// R5 - Converter mask bit 4 blocks the converter-1 current-limit event.
// R6 - Converter mask bit 3 blocks the converter-0 pg-invalid event.
// R7 - Converter mask bit 2 blocks the converter-0 pg-valid event.
// R8 - Converter mask bit 0 blocks the converter-0 current-limit event.
// R9 - Masks gate events only; raw status outputs follow the live inputs.
// R10 - Regulator mask at 0x23 mirrors the converter layout, bits 5, 1 always 0.
// R11 - Regulator mask bits use the same 0-allows, 1-blocks polarity.
// R12 - Events fire only on a source edge with mask 0; reserved bits read 0.
module rem_event_mask_bank
  import rem_pkg::*;
#(
  // Bus address default is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
  input  wire logic       SYS_CLK_I,
  input  wire logic       RSTN_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  input  wire logic       OTP_RESET_REG_SUPPRESS_I,
  input  wire logic       REG_RESET_REQ_I,
  input  wire logic [1:0] CONV_PG_RAW_I,
  input  wire logic [1:0] CONV_CURLIM_RAW_I,
  input  wire logic [1:0] REG_PG_RAW_I,
  input  wire logic [1:0] REG_CURLIM_RAW_I,
  output logic      [1:0] CONV_PG_RAW_O,
  output logic      [1:0] CONV_CURLIM_RAW_O,
  output logic      [1:0] REG_PG_RAW_O,
  output logic      [1:0] REG_CURLIM_RAW_O,
  output logic            RESET_REG_EVT_O,
  output logic      [1:0] CONV_PG_EVT_O,
  output logic      [1:0] CONV_CURLIM_EVT_O,
  output logic      [1:0] REG_PG_EVT_O,
  output logic      [1:0] REG_CURLIM_EVT_O
);

  // -------------------------------------------------------------------------
  // Mask gating shared by both regulator families
  // -------------------------------------------------------------------------
  // Raw pg status is 1 while invalid, so a rising raw level is a fall event
  function automatic logic [3:0] gate_events
  (
    input logic [1:0] pg_rise,
    input logic [1:0] pg_fall,
    input logic [1:0] cl_rise,
    input logic [7:0] m
  );
    logic [3:0] ev;
    ev    = '0;
    ev[1] = (pg_rise[1] & ~m[`REM_BIT_1_PGF])
          | (pg_fall[1] & ~m[`REM_BIT_1_PGR]);
    ev[0] = (pg_rise[0] & ~m[`REM_BIT_0_PGF])
          | (pg_fall[0] & ~m[`REM_BIT_0_PGR]);
    ev[3] = cl_rise[1] & ~m[`REM_BIT_1_ILIM];
    ev[2] = cl_rise[0] & ~m[`REM_BIT_0_ILIM];
    gate_events = ev;
  endfunction

  // Reserved bits 5 and 1 never store a one
  function automatic logic [7:0] keep_mask_bits
  (
    input logic [7:0] d
  );
    keep_mask_bits = d & `REM_MASK_WR_BITS;
  endfunction

  // -------------------------------------------------------------------------
  // Serial register port
  // -------------------------------------------------------------------------
  logic       wr_en;
  logic [7:0] reg_addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       sda_oe;

  rem_i2c_slave
  #(
    .DEV_ADDR (DEV_ADDR)
  )
  u_slave
  (
    .clk_i    (SYS_CLK_I),
    .rstn_i   (RSTN_I),
    .scl_i    (SCL_I),
    .sda_i    (SDA_I),
    .rdata_i  (rdata),
    .wr_en_o  (wr_en),
    .addr_o   (reg_addr),
    .wdata_o  (wdata),
    .sda_oe_o (sda_oe)
  );

  // -------------------------------------------------------------------------
  // Source edge detection
  // -------------------------------------------------------------------------
  logic [7:0] raw_q;
  logic [7:0] raw_rise;
  logic [7:0] raw_fall;

  rem_edge_detect
  #(
    .W (8)
  )
  u_edges
  (
    .clk_i   (SYS_CLK_I),
    .rstn_i  (RSTN_I),
    .level_i ({REG_CURLIM_RAW_I, REG_PG_RAW_I,
                CONV_CURLIM_RAW_I, CONV_PG_RAW_I}),
    .level_o (raw_q),
    .rise_o  (raw_rise),
    .fall_o  (raw_fall)
  );

  // -------------------------------------------------------------------------
  // Mask registers
  // -------------------------------------------------------------------------
  logic [7:0] conv_mask;
  logic [7:0] reg_mask;
  logic [6:0] top2_upper;
  logic       reset_reg_suppress;
  logic       otp_loaded;
  logic       reload_req;
  logic [7:0] next_conv_mask;
  logic [7:0] next_reg_mask;
  logic [6:0] next_top2_upper;
  logic       next_reset_reg_suppress;
  logic       next_otp_loaded;
  logic       next_reload_req;

  always_comb
  begin
    next_conv_mask          = conv_mask;
    next_reg_mask           = reg_mask;
    next_top2_upper         = top2_upper;
    next_reset_reg_suppress = reset_reg_suppress;
    next_otp_loaded         = 1'b1;
    next_reload_req         = REG_RESET_REQ_I;
    if (!otp_loaded || reload_req)
    begin
      // OTP copy taken on the clock after any reset, never under it
      next_reset_reg_suppress = OTP_RESET_REG_SUPPRESS_I;      // [R2]
    end
    // A register reset outranks a write on the same clock
    if (REG_RESET_REQ_I)
    begin
      next_conv_mask  = `REM_CONV_MASK_RST;
      next_reg_mask   = `REM_REG_MASK_RST;
      next_top2_upper = `REM_TOP2_UPPER_RST;
    end
    else if (wr_en)
    begin
      unique case (reg_addr)
        `REM_ADDR_TOP_MASK_2:
        begin
          // Bit 0 deliberately absent from the write path
          next_top2_upper = wdata[7:1];                         // [R2]
        end
        `REM_ADDR_CONV_MASK:
        begin
          next_conv_mask = keep_mask_bits(wdata);         // [R3] [R4] [R12]
        end
        `REM_ADDR_REG_MASK:
        begin
          next_reg_mask = keep_mask_bits(wdata);          // [R10] [R12]
        end
        default:
        begin
          next_conv_mask = conv_mask;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      conv_mask          <= `REM_CONV_MASK_RST;
      reg_mask           <= `REM_REG_MASK_RST;
      top2_upper         <= `REM_TOP2_UPPER_RST;
      reset_reg_suppress <= 1'b0;
      otp_loaded         <= 1'b0;
      reload_req         <= 1'b0;
    end
    else
    begin
      conv_mask          <= next_conv_mask;
      reg_mask           <= next_reg_mask;
      top2_upper         <= next_top2_upper;
      reset_reg_suppress <= next_reset_reg_suppress;
      otp_loaded         <= next_otp_loaded;
      reload_req         <= next_reload_req;
    end
  end

  // -------------------------------------------------------------------------
  // Readback
  // -------------------------------------------------------------------------
  always_comb
  begin
    unique case (reg_addr)
      `REM_ADDR_TOP_MASK_2:
      begin
        // Bit 0 shows the OTP copy, never a host write
        rdata = {top2_upper, reset_reg_suppress};
      end
      `REM_ADDR_CONV_MASK:
      begin
        rdata = conv_mask;                                      // [R12]
      end
      `REM_ADDR_REG_MASK:
      begin
        rdata = reg_mask;                                       // [R12]
      end
      default:
      begin
        rdata = `REM_READ_ZERO;
      end
    endcase
  end

  // -------------------------------------------------------------------------
  // Event gating and outputs
  // -------------------------------------------------------------------------
  logic       sda_out;
  logic       sda_en;
  logic [7:0] raw_out;
  logic       reset_evt;
  logic [3:0] conv_evt;
  logic [3:0] reg_evt;
  logic       next_sda_out;
  logic       next_sda_en;
  logic [7:0] next_raw_out;
  logic       next_reset_evt;
  logic [3:0] next_conv_evt;
  logic [3:0] next_reg_evt;

  always_comb
  begin
    // Gate with the freshly reloaded OTP value, one clock after the request
    next_reset_evt = reload_req & ~next_reset_reg_suppress;     // [R1]
    next_conv_evt  = gate_events(raw_rise[1:0], raw_fall[1:0],
                                 raw_rise[3:2],
                                 conv_mask); // [R3] [R4] [R5] [R6] [R7] [R8]
    next_reg_evt   = gate_events(raw_rise[5:4], raw_fall[5:4],
                                 raw_rise[7:6],
                                 reg_mask);        // [R10] [R11]
    next_sda_out   = 1'b0;
    next_sda_en    = sda_oe;
    next_raw_out   = raw_q;                                     // [R9]
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sda_out   <= 1'b0;
      sda_en    <= 1'b0;
      raw_out   <= '0;
      reset_evt <= 1'b0;
      conv_evt  <= '0;
      reg_evt   <= '0;
    end
    else
    begin
      sda_out   <= next_sda_out;
      sda_en    <= next_sda_en;
      raw_out   <= next_raw_out;                                // [R9]
      reset_evt <= next_reset_evt;
      conv_evt  <= next_conv_evt;                               // [R12]
      reg_evt   <= next_reg_evt;                                // [R12]
    end
  end

  // -------------------------------------------------------------------------
  // Output pins
  // -------------------------------------------------------------------------
  assign SDA_O             = sda_out;
  assign SDA_OE_O          = sda_en;
  assign CONV_PG_RAW_O     = raw_out[1:0];
  assign CONV_CURLIM_RAW_O = raw_out[3:2];
  assign REG_PG_RAW_O      = raw_out[5:4];
  assign REG_CURLIM_RAW_O  = raw_out[7:6];
  assign RESET_REG_EVT_O   = reset_evt;
  assign CONV_PG_EVT_O     = conv_evt[1:0];
  assign CONV_CURLIM_EVT_O = conv_evt[3:2];
  assign REG_PG_EVT_O      = reg_evt[1:0];
  assign REG_CURLIM_EVT_O  = reg_evt[3:2];

endmodule

// File: rem_event_mask_bank_assertions.sv
`timescale 1ns/1ns

module rem_event_mask_bank_checker
(
  input wire logic       SYS_CLK_I,
  input wire logic       RSTN_I,
  input wire logic       OTP_RESET_REG_SUPPRESS_I,
  input wire logic       REG_RESET_REQ_I,
  input wire logic [1:0] CONV_PG_RAW_I,
  input wire logic [1:0] CONV_CURLIM_RAW_I,
  input wire logic [1:0] REG_PG_RAW_I,
  input wire logic [1:0] REG_CURLIM_RAW_I,
  input wire logic [1:0] CONV_PG_RAW_O,
  input wire logic [1:0] CONV_CURLIM_RAW_O,
  input wire logic [1:0] REG_PG_RAW_O,
  input wire logic [1:0] REG_CURLIM_RAW_O,
  input wire logic       RESET_REG_EVT_O,
  input wire logic [1:0] CONV_PG_EVT_O,
  input wire logic [1:0] CONV_CURLIM_EVT_O,
  input wire logic [1:0] REG_PG_EVT_O,
  input wire logic [1:0] REG_CURLIM_EVT_O
);
  // -------------------------------------------------------------------------
  // Settling counter
  // -------------------------------------------------------------------------
  // Raw pipeline still holds reset values for the first edges
  logic [1:0] up;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
    if (!RSTN_I)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // -------------------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------------------
  a_raw_delay: assert property (up == 2'h3 |->
    {CONV_PG_RAW_O, CONV_CURLIM_RAW_O, REG_PG_RAW_O, REG_CURLIM_RAW_O} ==
    $past({CONV_PG_RAW_I, CONV_CURLIM_RAW_I, REG_PG_RAW_I,
           REG_CURLIM_RAW_I}, 2))
    else $error("raw status not two cycles behind input");
  a_conv1_pg_edge: assert property (CONV_PG_EVT_O[1] |->
    $changed(CONV_PG_RAW_O[1])) else $error("conv1 pg event without edge");
  a_conv0_pg_edge: assert property (CONV_PG_EVT_O[0] |->
    $changed(CONV_PG_RAW_O[0])) else $error("conv0 pg event without edge");
  a_conv1_cl_rise: assert property (CONV_CURLIM_EVT_O[1] |->
    $rose(CONV_CURLIM_RAW_O[1])) else $error("conv1 curlimit event bad");
  a_conv0_cl_rise: assert property (CONV_CURLIM_EVT_O[0] |->
    $rose(CONV_CURLIM_RAW_O[0])) else $error("conv0 curlimit event bad");
  a_reg_pg_edge: assert property (|REG_PG_EVT_O |->
    (REG_PG_EVT_O & ~(REG_PG_RAW_O ^ $past(REG_PG_RAW_O))) == 2'b00)
    else $error("regulator pg event without edge");
  a_reg_cl_rise: assert property (|REG_CURLIM_EVT_O |->
    (REG_CURLIM_EVT_O & ~(REG_CURLIM_RAW_O & ~$past(REG_CURLIM_RAW_O)))
      == 2'b00)
    else $error("regulator curlimit event without onset");
  a_rst_evt_cause: assert property (RESET_REG_EVT_O |->
    $past(REG_RESET_REQ_I, 2) && !$past(OTP_RESET_REG_SUPPRESS_I))
    else $error("reset event without unsuppressed request");
  a_rst_evt_fires: assert property (REG_RESET_REQ_I ##1
    !OTP_RESET_REG_SUPPRESS_I |=> RESET_REG_EVT_O)
    else $error("reset event missing");
endmodule

bind rem_event_mask_bank rem_event_mask_bank_checker u_chk (.*);

// File: rem_event_mask_bank_tb_top.sv
`timescale 1ns/1ns

module rem_event_mask_bank_tb_top;
  localparam logic [6:0] DEV = 7'h2A;
  logic       SYS_CLK_I, RSTN_I, SDA_I, SDA_O, SDA_OE_O, RESET_REG_EVT_O;
  logic       SCL_I, OTP_RESET_REG_SUPPRESS_I, REG_RESET_REQ_I, host_pull;
  logic [1:0] CONV_PG_RAW_I, CONV_CURLIM_RAW_I, REG_PG_RAW_I, REG_CURLIM_RAW_I;
  logic [1:0] CONV_PG_RAW_O, CONV_CURLIM_RAW_O, REG_PG_RAW_O, REG_CURLIM_RAW_O;
  logic [1:0] CONV_PG_EVT_O, CONV_CURLIM_EVT_O, REG_PG_EVT_O, REG_CURLIM_EVT_O;
  logic [7:0] raw, cm, rm, m;
  logic [8:0] evq[$];
  int         seed = 32'h0AD6;
  int         mismatches = 0;
  int         compares = 0;

  assign {CONV_PG_RAW_I, CONV_CURLIM_RAW_I,
          REG_PG_RAW_I, REG_CURLIM_RAW_I} = raw;
  // Open-drain wire with pull-up
  assign SDA_I = ~(host_pull | (SDA_OE_O & ~SDA_O));

  rem_event_mask_bank #(.DEV_ADDR(DEV)) u_dut (.*);
  rem_i2c_host #(.DEV_ADDR(DEV)) u_host (.clk_i(SYS_CLK_I), .sda_i(SDA_I),
    .scl_o(SCL_I), .sda_pull_o(host_pull));

  initial
  begin
    SYS_CLK_I = 1'b0;
    forever #10 SYS_CLK_I = ~SYS_CLK_I;
  end

  // -------------------------------------------------------------------------
  // Checking
  // -------------------------------------------------------------------------
  task automatic check(input string n, input logic [8:0] e, s);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Every event pulse consumes the oldest expectation
  always @(negedge SYS_CLK_I)
    if (RSTN_I === 1'b1 && {RESET_REG_EVT_O, CONV_PG_EVT_O, CONV_CURLIM_EVT_O,
        REG_PG_EVT_O, REG_CURLIM_EVT_O} !== 9'h000)
      check("event", (evq.size() == 0) ? 9'h000 : evq.pop_front(),
        {RESET_REG_EVT_O, CONV_PG_EVT_O, CONV_CURLIM_EVT_O, REG_PG_EVT_O,
         REG_CURLIM_EVT_O});

  initial
  begin
    repeat (40000) @(negedge SYS_CLK_I);
    mismatches++;
    $display("Error watchdog expired");
    wrap_up();
  end

  // -------------------------------------------------------------------------
  // Stimulus helpers
  // -------------------------------------------------------------------------
  function automatic logic [3:0] exp4(input logic [1:0] po, pn, co, cn,
                                      input logic [7:0] k);
    logic [3:0] e;
    for (int i = 0; i < 2; i++)
    begin
      e[2+i] = (~po[i] & pn[i] & ~k[3+4*i]) | (po[i] & ~pn[i] & ~k[2+4*i]);
      e[i] = ~co[i] & cn[i] & ~k[4*i];
    end
    return e;
  endfunction

  task automatic toggle();
    logic [7:0] n;
    logic [8:0] e;
    n = 8'($random(seed));
    e = {1'b0, exp4(raw[7:6], n[7:6], raw[5:4], n[5:4], cm),
         exp4(raw[3:2], n[3:2], raw[1:0], n[1:0], rm)};
    if (e != 9'h000)
      evq.push_back(e);
    raw = n;
    @(negedge SYS_CLK_I);
  endtask

  task automatic wr_chk(input logic [6:0] v, input logic [7:0] a, d);
    logic [2:0] k;
    u_host.wr(v, a, d, k);
    check("write ack", (v == DEV) ? 9'h000 : 9'h007, {6'h00, k});
  endtask

  task automatic rd_chk(input logic [7:0] a, e);
    logic [7:0] d;
    logic [3:0] k;
    u_host.rd(a, d, k);
    check("read ack", 9'h001, {5'h00, k});
    check("read data", {1'b0, e}, {1'b0, d});
  endtask

  task automatic req_pulse();
    REG_RESET_REQ_I = 1'b1;
    @(negedge SYS_CLK_I);
    REG_RESET_REQ_I = 1'b0;
    repeat (4) @(negedge SYS_CLK_I);
  endtask

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial
  begin
    RSTN_I = 1'b0;
    OTP_RESET_REG_SUPPRESS_I = 1'b0;
    REG_RESET_REQ_I = 1'b0;
    raw = 8'h00;
    repeat (2) @(negedge SYS_CLK_I);
    RSTN_I = 1'b1;
    repeat (2) @(negedge SYS_CLK_I);
    wr_chk(DEV, 8'h22, 8'hFF);
    rd_chk(8'h22, 8'hDD);
    wr_chk(DEV, 8'h23, 8'hFF);
    rd_chk(8'h23, 8'hDD);
    wr_chk(DEV, 8'h21, 8'hFF);
    rd_chk(8'h21, 8'hFE);
    wr_chk(7'h15, 8'h22, 8'h00);
    rd_chk(8'h22, 8'hDD);
    rd_chk(8'h30, 8'h00);
    $display("test registers done");
    // Fixed all-open and all-closed masks first, then random ones
    for (int k = 0; k < 12; k++)
    begin
      m = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
      wr_chk(DEV, 8'h22, m);
      cm = m & 8'hDD;
      m = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
      wr_chk(DEV, 8'h23, m);
      rm = m & 8'hDD;
      toggle();
      toggle();
      repeat (4) @(negedge SYS_CLK_I);
      check("raw status", {1'b0, raw}, {1'b0, CONV_PG_RAW_O,
        CONV_CURLIM_RAW_O, REG_PG_RAW_O, REG_CURLIM_RAW_O});
    end
    check("pending events", 9'h000, 9'(evq.size()));
    $display("test events done");
    evq.push_back(9'h100);
    req_pulse();
    rd_chk(8'h22, 8'h00);
    OTP_RESET_REG_SUPPRESS_I = 1'b1;
    req_pulse();
    rd_chk(8'h21, 8'h01);
    wr_chk(DEV, 8'h21, 8'h00);
    rd_chk(8'h21, 8'h01);
    check("pending events", 9'h000, 9'(evq.size()));
    $display("test register reset done");
    wrap_up();
  end
endmodule

// File: rem_i2c_host.sv
`timescale 1ns/1ns

module rem_i2c_host
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // Each bus clock phase spans four system clocks, above the two needed
  localparam int HALF = 4;

  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Data moves only while the bus clock is low
  task automatic slot(input logic b, output logic s);
    tick(1);
    sda_pull_o = ~b;
    tick(HALF - 1);
    scl_o = 1'b1;
    tick(HALF);
    s = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic start();
    tick(1);
    sda_pull_o = 1'b0;
    tick(HALF - 1);
    scl_o = 1'b1;
    tick(HALF);
    sda_pull_o = 1'b1;
    tick(HALF);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    tick(1);
    sda_pull_o = 1'b1;
    tick(HALF - 1);
    scl_o = 1'b1;
    tick(HALF);
    sda_pull_o = 1'b0;
    tick(HALF);
  endtask

  // Ninth slot is released by the host: ack on writes, nack on reads
  task automatic xfer(input logic [7:0] w, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      slot(w[i], r[i]);
    slot(1'b1, ack);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] a, d,
                    output logic [2:0] ack);
    logic [7:0] r;
    start();
    xfer({dev, 1'b0}, r, ack[2]);
    xfer(a, r, ack[1]);
    xfer(d, r, ack[0]);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic [3:0] ack);
    logic [7:0] r;
    start();
    xfer({DEV_ADDR, 1'b0}, r, ack[3]);
    xfer(a, r, ack[2]);
    start();
    xfer({DEV_ADDR, 1'b1}, r, ack[1]);
    xfer(8'hFF, d, ack[0]);
    stop();
  endtask
endmodule

// File: rem_i2c_slave.sv
`timescale 1ns/1ns
`include "rem_regs.svh"

module rem_i2c_slave
  import rem_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_en_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            sda_oe_o
);

  rem_i2c_state_e state;
  rem_i2c_state_e next_state;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_en;
  logic       oe;
  logic       rw;
  logic       acked;
  logic       next_scl_q;
  logic       next_sda_q;
  logic [3:0] next_cnt;
  logic [7:0] next_sh;
  logic [7:0] next_tx;
  logic [7:0] next_addr;
  logic [7:0] next_wdata;
  logic       next_wr_en;
  logic       next_oe;
  logic       next_rw;
  logic       next_acked;
  logic       start;
  logic       stop;
  logic       rise;
  logic       fall;
  logic       rx_state;

  assign start = scl_q & scl_i & sda_q & ~sda_i;
  assign stop  = scl_q & scl_i & ~sda_q & sda_i;
  assign rise  = ~scl_q & scl_i;
  assign fall  = scl_q & ~scl_i;
  assign rx_state = (state == REM_ST_DEVADDR) || (state == REM_ST_REGADDR)
                 || (state == REM_ST_WDATA);

  always_comb
  begin
    next_state = state;
    next_scl_q = scl_i;
    next_sda_q = sda_i;
    next_cnt   = cnt;
    next_sh    = sh;
    next_tx    = tx;
    next_addr  = addr;
    next_wdata = wdata;
    next_wr_en = 1'b0;
    next_oe    = oe;
    next_rw    = rw;
    next_acked = acked;
    if (start)
    begin
      next_state = REM_ST_DEVADDR;
      next_cnt   = '0;
      next_oe    = 1'b0;
    end
    else if (stop)
    begin
      next_state = REM_ST_IDLE;
      next_oe    = 1'b0;
    end
    else if (rx_state)
    begin
      if (rise && cnt != `REM_BYTE_BITS)
      begin
        next_sh  = {sh[6:0], sda_i};
        next_cnt = cnt + 4'h1;
      end
      else if (fall && cnt == `REM_BYTE_BITS)
      begin
        next_cnt = '0;
        next_oe  = 1'b1;
        if (state == REM_ST_DEVADDR)
        begin
          // Foreign address: stay off the bus until the next start
          if (sh[7:1] == DEV_ADDR)
          begin
            next_rw    = sh[0];
            next_state = REM_ST_ACK_DEV;
          end
          else
          begin
            next_oe    = 1'b0;
            next_state = REM_ST_IDLE;
          end
        end
        else if (state == REM_ST_REGADDR)
        begin
          next_addr  = sh;
          next_state = REM_ST_ACK_REG;
        end
        else
        begin
          next_wdata = sh;
          next_wr_en = 1'b1;
          next_state = REM_ST_ACK_WR;
        end
      end
    end
    else if (state == REM_ST_ACK_DEV && fall)
    begin
      if (rw)
      begin
        next_tx    = rdata_i;
        next_oe    = ~rdata_i[7];
        next_state = REM_ST_RDATA;
      end
      else
      begin
        next_oe    = 1'b0;
        next_state = REM_ST_REGADDR;
      end
    end
    else if (state == REM_ST_ACK_REG && fall)
    begin
      next_oe    = 1'b0;
      next_state = REM_ST_WDATA;
    end
    else if (state == REM_ST_ACK_WR && fall)
    begin
      next_oe    = 1'b0;
      next_addr  = addr + 8'h01;
      next_state = REM_ST_WDATA;
    end
    else if (state == REM_ST_RDATA && fall)
    begin
      if (cnt == `REM_LAST_BIT)
      begin
        next_cnt   = '0;
        next_oe    = 1'b0;
        next_state = REM_ST_ACK_RD;
      end
      else
      begin
        next_cnt = cnt + 4'h1;
        next_tx  = {tx[6:0], 1'b0};
        next_oe  = ~tx[6];
      end
    end
    else if (state == REM_ST_ACK_RD)
    begin
      if (rise)
      begin
        next_acked = ~sda_i;
        if (!sda_i)
        begin
          next_addr = addr + 8'h01;
        end
      end
      else if (fall)
      begin
        if (acked)
        begin
          next_tx    = rdata_i;
          next_oe    = ~rdata_i[7];
          next_state = REM_ST_RDATA;
        end
        else
        begin
          next_state = REM_ST_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= REM_ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt   <= '0;
      sh    <= '0;
      tx    <= '0;
      addr  <= '0;
      wdata <= '0;
      wr_en <= 1'b0;
      oe    <= 1'b0;
      rw    <= 1'b0;
      acked <= 1'b0;
    end
    else
    begin
      state <= next_state;
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
      cnt   <= next_cnt;
      sh    <= next_sh;
      tx    <= next_tx;
      addr  <= next_addr;
      wdata <= next_wdata;
      wr_en <= next_wr_en;
      oe    <= next_oe;
      rw    <= next_rw;
      acked <= next_acked;
    end
  end

  assign wr_en_o  = wr_en;
  assign addr_o   = addr;
  assign wdata_o  = wdata;
  assign sda_oe_o = oe;

endmodule

// File: rem_pkg.sv
package rem_pkg;

  typedef enum logic [8:0]
  {
    REM_ST_IDLE    = 9'h001,
    REM_ST_DEVADDR = 9'h002,
    REM_ST_ACK_DEV = 9'h004,
    REM_ST_REGADDR = 9'h008,
    REM_ST_ACK_REG = 9'h010,
    REM_ST_WDATA   = 9'h020,
    REM_ST_ACK_WR  = 9'h040,
    REM_ST_RDATA   = 9'h080,
    REM_ST_ACK_RD  = 9'h100
  } rem_i2c_state_e;

endpackage

// File: rem_regs.svh
`ifndef REM_REGS_SVH
`define REM_REGS_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define REM_ADDR_TOP_MASK_2   8'h21
`define REM_ADDR_CONV_MASK    8'h22
`define REM_ADDR_REG_MASK     8'h23

// ---------------------------------------------------------------------------
// Field positions (same layout in both per-source mask registers)
// ---------------------------------------------------------------------------
`define REM_BIT_1_PGF         7
`define REM_BIT_1_PGR         6
`define REM_BIT_1_ILIM        4
`define REM_BIT_0_PGF         3
`define REM_BIT_0_PGR         2
`define REM_BIT_0_ILIM        0
`define REM_BIT_RESET_REG     0

// ---------------------------------------------------------------------------
// Write masks and reset values
// ---------------------------------------------------------------------------
`define REM_MASK_WR_BITS      8'hDD
`define REM_CONV_MASK_RST     8'h00
`define REM_REG_MASK_RST      8'h00
`define REM_TOP2_UPPER_RST    7'h00
`define REM_READ_ZERO         8'h00

// ---------------------------------------------------------------------------
// Serial framing
// ---------------------------------------------------------------------------
`define REM_BYTE_BITS         4'h8
`define REM_LAST_BIT          4'h7

`endif
